// [src/pvla_defines.svh]
// Purpose: constants for the process variable level alarm block
// Assumes: 20 MHz clock, APB with 32-bit data
// Notes: offsets are byte addresses
`ifndef PVLA_DEFINES_SVH
`define PVLA_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PVLA_OFF_CONFIG 12'h000
`define PVLA_OFF_LOW_THR 12'h004
`define PVLA_OFF_LOW_TIME 12'h008
`define PVLA_OFF_HIGH_THR 12'h00c
`define PVLA_OFF_HIGH_TIME 12'h010
`define PVLA_OFF_HVAC_STATUS 12'h014
`define PVLA_OFF_MIN_LEVEL 12'h018
`define PVLA_OFF_MAX_LEVEL 12'h01c
`define PVLA_OFF_PV 12'h020
`define PVLA_OFF_EVENTS 12'h024

// ----------------------------------------
// reset values
// ----------------------------------------
`define PVLA_RST_CONFIG 16'h0000
`define PVLA_RST_LOW_THR 16'h0000
`define PVLA_RST_LOW_TIME 16'h01f4
`define PVLA_RST_HIGH_THR 16'h0384
`define PVLA_RST_HIGH_TIME 16'h01f4
`define PVLA_RST_MIN_LEVEL 16'h0000
`define PVLA_RST_MAX_LEVEL 16'h03e8

// ----------------------------------------
// status word bits
// ----------------------------------------
`define PVLA_BIT_SHORT_CYCLE 2
`define PVLA_BIT_DRY_PUMP 3
`define PVLA_BIT_BROKEN_BELT 4
`define PVLA_BIT_FILTER 5
`define PVLA_BIT_MAIN_MANUAL 6
`define PVLA_BIT_SLEEP 7
`define PVLA_BIT_EXT_MANUAL 8

// ----------------------------------------
// timing: persistence time unit is 10 ms
// ----------------------------------------
`define PVLA_CLOCK_HZ 20000000
`define PVLA_TICK_US 10000
`define PVLA_TICK_CYCLES ((`PVLA_CLOCK_HZ / 1000000) * `PVLA_TICK_US)

`endif

// [src/pvla_pkg.sv]
// Purpose: types for the process variable level alarm block
// Assumes: nothing beyond the defines header
// Notes: only types live here
package pvla_pkg;

  typedef enum logic [1:0] {
    PVLA_CFG_DISABLE,
    PVLA_CFG_ALARM,
    PVLA_CFG_FAULT,
    PVLA_CFG_UNUSED
  } pvla_cfg_type;

  typedef enum {
    PVLA_IDLE,
    PVLA_TIMING,
    PVLA_ALARM,
    PVLA_FAULT
  } pvla_state_type;

endpackage : pvla_pkg

// [src/pvla_level_detect.sv]
// Purpose: one persistence detector for a level condition
// Assumes: tick is a one-cycle pulse every time unit
// Notes: shared by the low and the high side
`timescale 1ns/1ps
`default_nettype none

module pvla_level_detect (
  input wire logic clock,
  input wire logic resetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic fault_mode,
  input wire logic condition,
  input wire logic [15:0] persist_time,
  input wire logic motor_stopped,
  output logic alarm,
  output logic fault,
  output logic raise_pulse
);

  pvla_pkg::pvla_state_type state_q;
  pvla_pkg::pvla_state_type state_d;
  logic [15:0] count_q;
  logic [15:0] count_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  wire logic armed = enable && (persist_time != 16'h0000) && condition; // R7 R10
  wire logic elapsed = tick && (count_q + 16'h0001 >= persist_time);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    raise_pulse = 1'b0;
    case (state_q)
      pvla_pkg::PVLA_IDLE: begin
        count_d = 16'h0000;
        if (armed) begin
          state_d = pvla_pkg::PVLA_TIMING;
        end
      end
      pvla_pkg::PVLA_TIMING: begin
        if (!armed) begin
          // an interrupted condition starts over
          state_d = pvla_pkg::PVLA_IDLE; // R21
          count_d = 16'h0000; // R21
        end else if (elapsed) begin
          state_d = pvla_pkg::PVLA_ALARM; // R6 R9
          raise_pulse = 1'b1;
        end else if (tick) begin
          count_d = count_q + 16'h0001;
        end
      end
      pvla_pkg::PVLA_ALARM: begin
        if (fault_mode && enable && motor_stopped) begin
          state_d = pvla_pkg::PVLA_FAULT; // R4 R11 R12
        end else if (!armed) begin
          state_d = pvla_pkg::PVLA_IDLE;
        end
      end
      pvla_pkg::PVLA_FAULT: begin
        // a fault latches until the supervision is disabled or fault mode is left
        if (!enable || !fault_mode) begin
          state_d = pvla_pkg::PVLA_IDLE;
        end
      end
      default: begin
        state_d = pvla_pkg::PVLA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= pvla_pkg::PVLA_IDLE;
      count_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign alarm = (state_q == pvla_pkg::PVLA_ALARM) || (state_q == pvla_pkg::PVLA_FAULT);
  assign fault = (state_q == pvla_pkg::PVLA_FAULT);

endmodule : pvla_level_detect

`default_nettype wire

// [src/pvla_top.sv]
// Purpose: process variable scaling, low/high level supervision and hvac status word
// Assumes: analog input is a 16-bit unsigned fraction of full scale, inputs synchronous
// Notes: registers on apb, one 32-bit aligned word each, 16-bit data in low bits
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pvla_defines.svh"

// What this block does
// (R1) Scaled value is span times normalised analog input plus minimum level.
// (R2) Configuration 0, the reset default, suppresses low and high supervision.
// (R3) Configuration 1 gives alarm only; external controller keeps driving motor.
// (R4) Configuration 2 alarms during deceleration, faults once motor has stopped.
// (R5) Low level when scaled value is below signed 16-bit low threshold.
// (R6) Low alarm after low condition persists for low time, default 5 s.
// (R7) Low persistence time zero disables low detection.
// (R8) High level when scaled value exceeds signed high threshold, default 900.
// (R9) High alarm after high condition persists for high time, default 5 s.
// (R10) High persistence time zero disables high detection.
// (R11) Fault mode: low fault only after motor decelerated and stopped.
// (R12) Fault mode: high fault only after motor decelerated and stopped.
// (R13) Read-only 16-bit status word; bits 0, 1, 9 to 15 reserved.
// (R14) Bit 2 is one while short cycle protection is active.
// (R15) Bit 3 is one when dry pump was detected.
// (R16) Bit 4 is one when broken belt was detected.
// (R17) Bit 5 is one when filter maintenance alarm was detected.
// (R18) Bit 6 is one while main controller is in manual mode.
// (R19) Bit 7 is one while the drive is in sleep mode.
// (R20) Bit 8 is one while external controller is in manual mode.
// (R21) Persistence timer restarts from zero when its condition clears early.
// (R22) Threshold comparisons are strict and signed.
module pvla_top #(
  parameter int unsigned TICK_CYCLES = `PVLA_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [15:0] analog_input,
  input wire logic motor_stopped,
  input wire logic short_cycle_active,
  input wire logic dry_pump_detected,
  input wire logic broken_belt_detected,
  input wire logic filter_alarm_detected,
  input wire logic main_pid_manual,
  input wire logic sleep_mode_active,
  input wire logic ext_pid_manual,
  output logic low_alarm,
  output logic high_alarm,
  output logic low_fault,
  output logic high_fault,
  output logic ext_pid_active,
  output logic [15:0] scaled_process_variable
);

  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("pvla_top: TICK_CYCLES must be at least 2");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] pv_alarm_configuration_q;
  logic [15:0] pv_low_threshold_q;
  logic [15:0] pv_low_persist_time_q;
  logic [15:0] pv_high_threshold_q;
  logic [15:0] pv_high_persist_time_q;
  logic [15:0] pv_minimum_level_q;
  logic [15:0] pv_maximum_level_q;
  logic [1:0] events_q;
  logic [31:0] tick_count_q;
  logic tick_q;
  logic [15:0] pv_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // every access completes in its first access cycle
  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic rd = access && !pwrite;
  wire logic hit_cfg = (paddr == `PVLA_OFF_CONFIG);
  wire logic hit_lthr = (paddr == `PVLA_OFF_LOW_THR);
  wire logic hit_ltim = (paddr == `PVLA_OFF_LOW_TIME);
  wire logic hit_hthr = (paddr == `PVLA_OFF_HIGH_THR);
  wire logic hit_htim = (paddr == `PVLA_OFF_HIGH_TIME);
  wire logic hit_stat = (paddr == `PVLA_OFF_HVAC_STATUS);
  wire logic hit_min = (paddr == `PVLA_OFF_MIN_LEVEL);
  wire logic hit_max = (paddr == `PVLA_OFF_MAX_LEVEL);
  wire logic hit_pv = (paddr == `PVLA_OFF_PV);
  wire logic hit_evt = (paddr == `PVLA_OFF_EVENTS);
  wire logic hit_rw = hit_cfg | hit_lthr | hit_ltim | hit_hthr | hit_htim | hit_min | hit_max | hit_evt;
  wire logic hit_any = hit_rw | hit_stat | hit_pv;
  // read-only words refuse writes with an error
  wire logic bad = !hit_any || (pwrite && (hit_stat || hit_pv));

  // ----------------------------------------
  // scaling
  // ----------------------------------------
  // span kept in 17 bits so min/max at the rails do not overflow
  wire logic signed [16:0] span = $signed({pv_maximum_level_q[15], pv_maximum_level_q})
                                 - $signed({pv_minimum_level_q[15], pv_minimum_level_q});
  wire logic signed [33:0] product = span * $signed({1'b0, analog_input});
  wire logic signed [17:0] scaled_wide = $signed(product[33:16])
                                        + $signed({{2{pv_minimum_level_q[15]}}, pv_minimum_level_q}); // R1

  function automatic logic [15:0] pvla_saturate(input logic signed [17:0] v);
    if (v > 18'sh07fff) begin
      pvla_saturate = 16'h7fff;
    end else if (v < -18'sh08000) begin
      pvla_saturate = 16'h8000;
    end else begin
      pvla_saturate = v[15:0];
    end
  endfunction : pvla_saturate

  wire logic [15:0] pv_d = pvla_saturate(scaled_wide);

  // ----------------------------------------
  // comparisons and mode
  // ----------------------------------------
  wire logic is_low = $signed(pv_q) < $signed(pv_low_threshold_q); // R5 R22
  wire logic is_high = $signed(pv_q) > $signed(pv_high_threshold_q); // R8 R22
  wire logic [1:0] cfg_sel = pv_alarm_configuration_q[1:0];
  wire logic sup_on = (cfg_sel == pvla_pkg::PVLA_CFG_ALARM) || (cfg_sel == pvla_pkg::PVLA_CFG_FAULT); // R2
  wire logic fault_mode = (cfg_sel == pvla_pkg::PVLA_CFG_FAULT);

  logic low_alarm_w;
  logic low_fault_w;
  logic low_raise;
  logic high_alarm_w;
  logic high_fault_w;
  logic high_raise;

  pvla_level_detect u_low (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_q),
    .enable(sup_on), // R2
    .fault_mode(fault_mode),
    .condition(is_low),
    .persist_time(pv_low_persist_time_q), // R7
    .motor_stopped(motor_stopped),
    .alarm(low_alarm_w),
    .fault(low_fault_w),
    .raise_pulse(low_raise)
  );

  pvla_level_detect u_high (
    .clock(clock),
    .resetn(resetn),
    .tick(tick_q),
    .enable(sup_on), // R2
    .fault_mode(fault_mode),
    .condition(is_high),
    .persist_time(pv_high_persist_time_q), // R10
    .motor_stopped(motor_stopped),
    .alarm(high_alarm_w),
    .fault(high_fault_w),
    .raise_pulse(high_raise)
  );

  // ----------------------------------------
  // status word
  // ----------------------------------------
  wire logic [15:0] status_word = {
    7'h00, // R13
    ext_pid_manual, // R20
    sleep_mode_active, // R19
    main_pid_manual, // R18
    filter_alarm_detected, // R17
    broken_belt_detected, // R16
    dry_pump_detected, // R15
    short_cycle_active, // R14
    2'h0 // R13
  };

  wire logic [15:0] rd_word =
      hit_cfg ? pv_alarm_configuration_q :
      hit_lthr ? pv_low_threshold_q :
      hit_ltim ? pv_low_persist_time_q :
      hit_hthr ? pv_high_threshold_q :
      hit_htim ? pv_high_persist_time_q :
      hit_stat ? status_word :
      hit_min ? pv_minimum_level_q :
      hit_max ? pv_maximum_level_q :
      hit_pv ? pv_q :
      hit_evt ? {14'h0000, events_q} : 16'h0000;

  // event bits: hardware set wins over write-one-to-clear
  wire logic [1:0] evt_set = {high_raise, low_raise};
  wire logic [1:0] evt_clr = (wr && hit_evt) ? pwdata[1:0] : 2'h0;
  wire logic tick_wrap = (tick_count_q == TICK_CYCLES - 1);

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // a write lands at the edge that closes the access phase
  wire logic wr_cfg = wr && hit_cfg;
  wire logic wr_lthr = wr && hit_lthr;
  wire logic wr_ltim = wr && hit_ltim;
  wire logic wr_hthr = wr && hit_hthr;
  wire logic wr_htim = wr && hit_htim;
  wire logic wr_min = wr && hit_min;
  wire logic wr_max = wr && hit_max;
  // the answer is prepared in setup, so pready stands in the first access cycle
  wire logic setup = psel && !penable;
  // alarm mode leaves the controller running; fault mode stops it
  wire logic ext_active_d = !(fault_mode && (low_alarm_w || high_alarm_w)); // R3 R4

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_alarm_configuration_q <= `PVLA_RST_CONFIG;
    end else if (wr_cfg) begin
      pv_alarm_configuration_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_low_threshold_q <= `PVLA_RST_LOW_THR;
    end else if (wr_lthr) begin
      pv_low_threshold_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_low_persist_time_q <= `PVLA_RST_LOW_TIME;
    end else if (wr_ltim) begin
      pv_low_persist_time_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_high_threshold_q <= `PVLA_RST_HIGH_THR;
    end else if (wr_hthr) begin
      pv_high_threshold_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_high_persist_time_q <= `PVLA_RST_HIGH_TIME;
    end else if (wr_htim) begin
      pv_high_persist_time_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_minimum_level_q <= `PVLA_RST_MIN_LEVEL;
    end else if (wr_min) begin
      pv_minimum_level_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_maximum_level_q <= `PVLA_RST_MAX_LEVEL;
    end else if (wr_max) begin
      pv_maximum_level_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_count_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      tick_count_q <= tick_wrap ? 32'h00000000 : tick_count_q + 32'h00000001;
      tick_q <= tick_wrap;
    end
  end

  // ----------------------------------------
  // scaled value and events
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pv_q <= 16'h0000;
    end else begin
      pv_q <= pv_d; // R1
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      events_q <= 2'h0;
    end else begin
      events_q <= (events_q & ~evt_clr) | evt_set;
    end
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && bad;
      prdata <= (setup && !pwrite) ? {16'h0000, rd_word} : 32'h00000000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_alarm <= 1'b0;
      high_alarm <= 1'b0;
      low_fault <= 1'b0;
      high_fault <= 1'b0;
    end else begin
      low_alarm <= low_alarm_w; // R6
      high_alarm <= high_alarm_w; // R9
      low_fault <= low_fault_w; // R11
      high_fault <= high_fault_w; // R12
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_pid_active <= 1'b1;
      scaled_process_variable <= 16'h0000;
    end else begin
      ext_pid_active <= ext_active_d; // R3 R4
      scaled_process_variable <= pv_q;
    end
  end

endmodule : pvla_top

`default_nettype wire

// [test/pvla_top_asserts.sv]
// Purpose: port-level checks of pvla_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every pvla_top instance
`timescale 1ns/1ps
`default_nettype none
module pvla_top_asserts #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic motor_stopped,
  input wire logic low_alarm,
  input wire logic high_alarm,
  input wire logic low_fault,
  input wire logic high_fault,
  input wire logic ext_pid_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ro_write_err_a: assert property (pready && pwrite && paddr == 12'h014 |-> pslverr)
    else $error("status write not refused");
  data_width_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  status_rsvd_a: assert property (pready && !pwrite && paddr == 12'h014 |-> prdata[15:9] == 7'h00 && prdata[1:0] == 2'b00)
    else $error("reserved status bits set");
  low_fault_alarm_a: assert property (low_fault |-> low_alarm)
    else $error("low fault without alarm");
  high_fault_alarm_a: assert property (high_fault |-> high_alarm)
    else $error("high fault without alarm");
  low_fault_stop_a: assert property (!motor_stopped [*3] |-> !$rose(low_fault))
    else $error("low fault while spinning");
  high_fault_stop_a: assert property (!motor_stopped [*3] |-> !$rose(high_fault))
    else $error("high fault while spinning");
  ext_release_a: assert property ($fell(ext_pid_active) |-> ##[0:2] (low_alarm || high_alarm))
    else $error("controller released without alarm");
endmodule : pvla_top_asserts

bind pvla_top pvla_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) pvla_top_asserts_inst (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .motor_stopped(motor_stopped), .low_alarm(low_alarm),
  .high_alarm(high_alarm), .low_fault(low_fault), .high_fault(high_fault), .ext_pid_active(ext_pid_active));
`default_nettype wire

// [test/pvla_top_test.sv]
// Purpose: self-checking bench for pvla_top
// Assumes: tick shortened to 4 cycles, 20 MHz clock
// Notes: xorshift stimulus from a fixed seed, corner cases mixed in
`timescale 1ns/1ps
`default_nettype none
module pvla_top_test;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  localparam int unsigned TK = 4;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] ai = 16'h0000;
  logic ms = 1'b0;
  logic [6:0] st = 7'h00;
  logic pready, pslverr, la, ha, lf, hf, ext, er;
  logic [31:0] prdata, rd;
  logic [15:0] pv, d, mn, mx;
  logic [31:0] rng = 32'h00000043;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h018, 12'h01c, 12'h024};
  logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h01f4, 16'h0384, 16'h01f4, 16'h0000, 16'h03e8, 16'h0000};
  // suppression cases: config off, times zero, values equal to thresholds
  logic [15:0] cf [3] = '{16'h0000, 16'h0001, 16'h0001};
  logic [15:0] lt [3] = '{16'h0064, 16'h0064, 16'h0000};
  logic [15:0] tm [3] = '{16'h0005, 16'h0000, 16'h0005};
  logic [15:0] ht [3] = '{16'h0384, 16'h0384, 16'h03e7};

  always #25 clock = ~clock;

  pvla_top #(.TICK_CYCLES(TK)) pvla_top_inst (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .analog_input(ai),
    .motor_stopped(ms), .short_cycle_active(st[0]), .dry_pump_detected(st[1]), .broken_belt_detected(st[2]),
    .filter_alarm_detected(st[3]), .main_pid_manual(st[4]), .sleep_mode_active(st[5]), .ext_pid_manual(st[6]),
    .low_alarm(la), .high_alarm(ha), .low_fault(lf), .high_fault(hf), .ext_pid_active(ext),
    .scaled_process_variable(pv));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [15:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction : nxt

  function automatic logic [15:0] exp_pv(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] a);
    longint v;
    v = ((longint'($signed(hi)) - longint'($signed(lo))) * longint'(a)) >>> 16;
    v = v + longint'($signed(lo));
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction : exp_pv

  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // one idle edge first, so a release and the next setup never share a time step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      n++;
      @(posedge clock);
    end
    chk(n, 0, "wait states");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    apb(a, 1'b1, {16'h0000, v});
  endtask : wr

  // config goes last so thresholds are in place before supervision starts
  task automatic cfg5(input logic [15:0] c, input logic [15:0] l, input logic [15:0] lm,
                      input logic [15:0] h, input logic [15:0] hm);
    wr(12'h004, l);
    wr(12'h008, lm);
    wr(12'h00c, h);
    wr(12'h010, hm);
    wr(12'h000, c);
  endtask : cfg5

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      chk(1'b1, 1'b0, "timeout");
      end_sim();
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(ra[i], 1'b0, 32'h00000000);
      chk(rd, {16'h0000, rv[i]}, "reset value");
    end
    for (int i = 0; i < 7; i++) begin
      d = nxt();
      if (i == 0) d[15:2] = 14'h0000;
      if (i == 2 || i == 4) d[15] = 1'b0;
      wr(ra[i], d);
      apb(ra[i], 1'b0, 32'h00000000);
      chk(rd, {16'h0000, d}, "readback");
      chk(er, 1'b0, "good access");
    end
    wr(12'h014, 16'hffff);
    chk(er, 1'b1, "status write");
    apb(12'h028, 1'b0, 32'h00000000);
    chk(er, 1'b1, "unmapped read");
    for (int i = 0; i < 5; i++) begin
      d = nxt();
      st <= (i == 0) ? 7'h7f : d[6:0];
      apb(12'h014, 1'b0, 32'h00000000);
      chk(rd, {23'h000000, st, 2'b00}, "status word");
    end
    for (int i = 0; i < 6; i++) begin
      mn = nxt();
      mx = nxt();
      d = nxt();
      if (i == 0) begin
        mn = 16'h8000;
        mx = 16'h7fff;
        d = 16'hffff;
      end
      wr(12'h018, mn);
      wr(12'h01c, mx);
      ai <= d;
      repeat (4) @(posedge clock);
      chk(pv, exp_pv(mn, mx, d), "scaled value");
    end
    wr(12'h018, 16'h0000);
    wr(12'h01c, 16'h03e8);
    for (int j = 0; j < 3; j++) begin
      cfg5(cf[j], lt[j], tm[j], ht[j], tm[j]);
      ai <= 16'h0000;
      repeat (40) @(posedge clock);
      chk(la, 1'b0, "low suppressed");
      ai <= 16'hffff;
      repeat (40) @(posedge clock);
      chk(ha, 1'b0, "high suppressed");
    end
    cfg5(16'h0001, 16'h0064, 16'h0005, 16'h0384, 16'h0005);
    ai <= 16'h8000;
    repeat (8) @(posedge clock);
    ai <= 16'h0000;
    repeat (12) @(posedge clock);
    ai <= 16'h8000;
    repeat (4) @(posedge clock);
    ai <= 16'h0000;
    repeat (16) @(posedge clock);
    chk(la, 1'b0, "timer restart");
    repeat (16) @(posedge clock);
    chk(la, 1'b1, "low alarm");
    chk(ext, 1'b1, "controller kept");
    apb(12'h024, 1'b0, 32'h00000000);
    chk(rd[0], 1'b1, "low event");
    wr(12'h024, 16'h0001);
    apb(12'h024, 1'b0, 32'h00000000);
    chk(rd[0], 1'b0, "event clear");
    ai <= 16'h8000;
    repeat (6) @(posedge clock);
    chk(la, 1'b0, "low cleared");
    for (int s = 0; s < 2; s++) begin
      cfg5(16'h0002, 16'h0064, 16'h0005, 16'h0384, 16'h0005);
      ai <= s ? 16'hffff : 16'h0000;
      repeat (32) @(posedge clock);
      chk(s ? ha : la, 1'b1, "alarm in decel");
      chk(s ? hf : lf, 1'b0, "fault while spinning");
      chk(ext, 1'b0, "controller released");
      apb(12'h024, 1'b0, 32'h00000000);
      chk(rd[s], 1'b1, "raise event");
      ms <= 1'b1;
      repeat (5) @(posedge clock);
      chk(s ? hf : lf, 1'b1, "fault after stop");
      wr(12'h000, 16'h0000);
      ms <= 1'b0;
      ai <= 16'h8000;
      repeat (4) @(posedge clock);
      chk(lf | hf, 1'b0, "fault cleared");
    end
    end_sim();
  end
endmodule : pvla_top_test
`default_nettype wire
